// File: include/sdd_params.svh
`ifndef SDD_PARAMS_SVH
`define SDD_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SDD_ADDR_GLOBAL 8'h00
`define SDD_ADDR_CHIDX 8'h04
`define SDD_ADDR_WORD_A 8'h08
`define SDD_ADDR_WORD_B 8'h0C
`define SDD_ADDR_WORD_C 8'h10
`define SDD_ADDR_STATUS 8'h14
`define SDD_ADDR_RESULT 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDD_GLB_SHORT 0
`define SDD_GLB_RUN 1
`define SDD_A_POS_LSB 0
`define SDD_A_NEG_LSB 4
`define SDD_A_HIGHVOLT_PATH_SELECT 8
`define SDD_A_NODE_LSB 12
`define SDD_B_RATE_LSB 0
`define SDD_B_ORDER_LSB 8
`define SDD_C_NORMAL 0
`define SDD_C_CHOP 1
`define SDD_C_WAIT_LSB 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SDD_RST_GLOBAL 16'h0000
`define SDD_RST_WORD_A 16'h0100
`define SDD_RST_WORD_B 16'h0000
`define SDD_RST_WORD_C 16'h0001

// ----------------------------------------------------------------
// Filter, timing and input mux constants
// ----------------------------------------------------------------
`define SDD_MOD_DIV 4'd2
`define SDD_MOD_POS 13'h0800
`define SDD_MOD_NEG 13'h1800
`define SDD_STAGE1_HEAD 8'd12
`define SDD_STAGE1_ORDER 3'd4
`define SDD_LOWRATE_OSR1 12'd128
`define SDD_LAST_BYPASS_CODE 5'd11
`define SDD_MAX_CODE 5'd28
`define SDD_MAX_ORDER 3'd4
`define SDD_WAIT_UNIT 64
`define SDD_NODE_BASE 4'h9
`define SDD_NODE_LAST 3'd5
`define SDD_ROUTE_AMP 6

`endif

// File: include/sdd_pkg.sv
package sdd_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } sdd_state_type;

  typedef struct packed {
    logic two_stage;
    logic [11:0] osr1;
    logic [11:0] osr2;
  } sdd_rate_type;

  // Smallest n with 2**n >= v.
  function automatic logic [7:0] sdd_ceil_log2(input logic [11:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 12; i++)
    begin
      if ((12'h001 << i) < v)
      begin
        n = 8'(i + 1);
      end
    end
    return n;
  endfunction : sdd_ceil_log2

endpackage : sdd_pkg

// File: core/sdd_lvmux.sv
`timescale 1ns/1ps
`include "sdd_params.svh"

module sdd_lvmux (
  input wire logic clk,
  input wire logic reset,
  input wire logic highvolt_path_select,
  input wire logic [3:0] positive_input_select,
  input wire logic [3:0] negative_input_select,
  input wire logic [2:0] internal_node_select,
  output logic [6:0] node_route,
  output logic select_error
);

  typedef struct packed {
    logic [6:0] route;
    logic err;
  } sdd_mux_state_type;

  sdd_mux_state_type r;
  sdd_mux_state_type n;

  always_comb
  begin
    n = '0;
    if (highvolt_path_select)
    begin
      n.route[`SDD_ROUTE_AMP] = 1'b1;
    end
    else if (positive_input_select == negative_input_select &&
             internal_node_select <= `SDD_NODE_LAST &&
             positive_input_select ==
             `SDD_NODE_BASE + {1'b0, internal_node_select})
    begin
      n.route[internal_node_select] = 1'b1;
    end
    else
    begin
      n.err = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign node_route = r.route;
  assign select_error = r.err;

endmodule : sdd_lvmux

// File: core/sdd_sinc.sv
`timescale 1ns/1ps

module sdd_sinc #(
  parameter int IN_W = 13,
  parameter int ACC_W = 48,
  parameter int OUT_W = 24,
  parameter int RATIO_W = 12,
  parameter int MAX_ORDER = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic in_valid,
  input wire logic [IN_W-1:0] in_data,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic [2:0] order,
  input wire logic [7:0] shift,
  output logic out_valid,
  output logic [OUT_W-1:0] out_data
);

  if (ACC_W <= IN_W || MAX_ORDER < 1 || MAX_ORDER > 4 || OUT_W > ACC_W)
  begin : g_check
    $error("sdd_sinc: unsupported width or order");
  end

  typedef struct packed {
    logic [MAX_ORDER-1:0][ACC_W-1:0] integ;
    logic [MAX_ORDER-1:0][ACC_W-1:0] dly;
    logic [RATIO_W-1:0] cnt;
    logic out_valid;
    logic [OUT_W-1:0] out_data;
  } sdd_sinc_state_type;

  localparam logic signed [ACC_W-1:0] MAX_OUT =
    ACC_W'({1'b0, {(OUT_W-1){1'b1}}});
  localparam logic signed [ACC_W-1:0] MIN_OUT = -MAX_OUT - ACC_W'(1);

  sdd_sinc_state_type r;
  sdd_sinc_state_type n;
  logic signed [ACC_W-1:0] x;
  logic signed [ACC_W-1:0] y;
  logic signed [ACC_W-1:0] scaled;

  // Integrators run at the input rate, the comb chain at the output
  // rate; only the first 'order' sections take part in the result.
  always_comb
  begin
    n = r;
    x = '0;
    y = '0;
    scaled = '0;
    n.out_valid = 1'b0;
    if (restart)
    begin
      n.integ = '0;
      n.dly = '0;
      n.cnt = '0;
    end
    else if (in_valid)
    begin
      n.integ[0] = r.integ[0] + ACC_W'($signed(in_data));
      for (int k = 1; k < MAX_ORDER; k++)
      begin
        n.integ[k] = r.integ[k] + r.integ[k-1];
      end
      if (r.cnt == ratio - RATIO_W'(1))
      begin
        n.cnt = '0;
        x = n.integ[order - 3'd1];
        for (int k = 0; k < MAX_ORDER; k++)
        begin
          if (k < int'(order))
          begin
            y = x - r.dly[k];
            n.dly[k] = x;
            x = y;
          end
        end
        scaled = x >>> shift;
        if (scaled > MAX_OUT)
        begin
          n.out_data = MAX_OUT[OUT_W-1:0];
        end
        else if (scaled < MIN_OUT)
        begin
          n.out_data = MIN_OUT[OUT_W-1:0];
        end
        else
        begin
          n.out_data = scaled[OUT_W-1:0];
        end
        n.out_valid = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt + RATIO_W'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign out_valid = r.out_valid;
  assign out_data = r.out_data;

endmodule : sdd_sinc

// File: core/sdd_decim.sv
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sdd_params.svh"

module sdd_decim
  import sdd_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int WAIT_UNIT = `SDD_WAIT_UNIT
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic mod_clk_out,
  input wire logic mod_bit_in,
  output logic offset_swap_out,
  output logic [6:0] node_route,
  output logic node_select_error,
  output logic [23:0] result_data,
  output logic result_valid,
  output logic [2:0] result_channel
);

  if (NUM_CH < 1 || NUM_CH > 8 || WAIT_UNIT < 1 || WAIT_UNIT > 1023)
  begin : g_check
    $error("sdd_decim: unsupported channel count or wait unit");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] mod_cnt;
    logic mod_clk;
    logic sync1;
    logic sync2;
    logic s1_valid;
    logic [12:0] s1_data;
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] glob;
    logic [2:0] chidx;
    logic [7:0][15:0] word_a;
    logic [7:0][15:0] word_b;
    logic [7:0][15:0] word_c;
    sdd_state_type state;
    logic restart;
    logic [3:0] skip;
    logic chop_phase;
    logic swap;
    logic [23:0] first;
    logic [15:0] wait_cnt;
    logic [15:0] result_count;
    logic [23:0] result;
    logic result_valid;
    logic [2:0] result_ch;
  } sdd_top_state_type;

  sdd_top_state_type r;
  sdd_top_state_type n;

  // ----------------------------------------------------------------
  // Rate table
  // ----------------------------------------------------------------
  // First-stage ratios are counted in modulator samples, second-stage
  // ratios in first-stage outputs; the slow codes run the first stage at
  // a fixed ratio of 128 and decimate the rest in the second stage.
  function automatic sdd_rate_type sdd_rate_info(input logic [4:0] code);
    sdd_rate_type t;
    t.two_stage = (code > `SDD_LAST_BYPASS_CODE);
    t.osr1 = `SDD_LOWRATE_OSR1;
    t.osr2 = 12'd1;
    case (code)
      5'd0: t.osr1 = 12'd8;
      5'd1: t.osr1 = 12'd12;
      5'd2: t.osr1 = 12'd16;
      5'd3: t.osr1 = 12'd24;
      5'd4: t.osr1 = 12'd32;
      5'd5: t.osr1 = 12'd48;
      5'd6: t.osr1 = 12'd64;
      5'd7: t.osr1 = 12'd96;
      5'd8: t.osr1 = 12'd128;
      5'd9: t.osr1 = 12'd192;
      5'd10: t.osr1 = 12'd256;
      5'd11: t.osr1 = 12'd384;
      5'd12: t.osr2 = 12'd4;
      5'd13: t.osr2 = 12'd6;
      5'd14: t.osr2 = 12'd8;
      5'd15: t.osr2 = 12'd16;
      5'd16: t.osr2 = 12'd32;
      5'd17: t.osr2 = 12'd45;
      5'd18: t.osr2 = 12'd60;
      5'd19: t.osr2 = 12'd90;
      5'd20: t.osr2 = 12'd180;
      5'd21: t.osr2 = 12'd300;
      5'd22: t.osr2 = 12'd360;
      5'd23: t.osr2 = 12'd600;
      5'd24: t.osr2 = 12'd720;
      5'd25: t.osr2 = 12'd900;
      5'd26: t.osr2 = 12'd1200;
      5'd27: t.osr2 = 12'd1800;
      default: t.osr2 = 12'd2400;
    endcase
    return t;
  endfunction : sdd_rate_info

  function automatic logic [15:0] sdd_merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] be
  );
    logic [15:0] v;
    v = old;
    if (be[0])
    begin
      v[7:0] = data[7:0];
    end
    if (be[1])
    begin
      v[15:8] = data[15:8];
    end
    return v;
  endfunction : sdd_merge16

  // ----------------------------------------------------------------
  // Active channel setup
  // ----------------------------------------------------------------
  logic [15:0] cur_a;
  logic [15:0] cur_b;
  logic [15:0] cur_c;
  logic [4:0] code;
  logic [2:0] ord_raw;
  logic [2:0] ord2;
  sdd_rate_type info;
  logic [7:0] shift1;
  logic [7:0] shift2;
  logic [3:0] settle_skip;
  logic run_en;
  logic normal_mode;
  logic chop_en;

  always_comb
  begin
    cur_a = r.word_a[r.chidx];
    cur_b = r.word_b[r.chidx];
    cur_c = r.word_c[r.chidx];
    code = cur_b[`SDD_B_RATE_LSB +: 5];
    if (code > `SDD_MAX_CODE)
    begin
      code = `SDD_MAX_CODE;
    end
    info = sdd_rate_info(code);
    ord_raw = cur_b[`SDD_B_ORDER_LSB +: 3];
    if (ord_raw == 3'd0)
    begin
      ord2 = 3'd1;
    end
    else if (ord_raw > `SDD_MAX_ORDER)
    begin
      ord2 = `SDD_MAX_ORDER;
    end
    else
    begin
      ord2 = ord_raw;
    end
    // Gains are rounded up to a power of two; full-scale input still saturates stage one at power-of-two ratios.
    shift1 = (sdd_ceil_log2(info.osr1) << 2) - `SDD_STAGE1_HEAD;
    shift2 = 8'(sdd_ceil_log2(info.osr2) * ord2);
    // Settling takes as many outputs as the order of the last stage.
    settle_skip = info.two_stage ? {1'b0, ord2 - 3'd1}
                                 : {1'b0, `SDD_STAGE1_ORDER - 3'd1};
    run_en = r.glob[`SDD_GLB_RUN];
    normal_mode = cur_c[`SDD_C_NORMAL];
    chop_en = cur_c[`SDD_C_CHOP];
  end

  // ----------------------------------------------------------------
  // Filter stages
  // ----------------------------------------------------------------
  logic filt_restart;
  logic s1_ov;
  logic [23:0] s1_od;
  logic s2_ov;
  logic [23:0] s2_od;
  logic fo_valid;
  logic [23:0] fo_data;

  assign filt_restart = r.restart || (r.state != ST_RUN);

  sdd_sinc #(
    .IN_W(13),
    .ACC_W(48),
    .OUT_W(24),
    .RATIO_W(12),
    .MAX_ORDER(4)
  ) u_stage1 (
    .clk(core_clk),
    .reset(reset),
    .restart(filt_restart),
    .in_valid(r.s1_valid),
    .in_data(r.s1_data),
    .ratio(info.osr1),
    .order(`SDD_STAGE1_ORDER),
    .shift(shift1),
    .out_valid(s1_ov),
    .out_data(s1_od)
  );

  sdd_sinc #(
    .IN_W(24),
    .ACC_W(72),
    .OUT_W(24),
    .RATIO_W(12),
    .MAX_ORDER(4)
  ) u_stage2 (
    .clk(core_clk),
    .reset(reset),
    .restart(filt_restart),
    .in_valid(s1_ov && info.two_stage),
    .in_data(s1_od),
    .ratio(info.osr2),
    .order(ord2),
    .shift(shift2),
    .out_valid(s2_ov),
    .out_data(s2_od)
  );

  assign fo_valid = info.two_stage ? s2_ov : s1_ov;
  assign fo_data = info.two_stage ? s2_od : s1_od;

  sdd_lvmux u_lvmux (
    .clk(core_clk),
    .reset(reset),
    .highvolt_path_select(cur_a[`SDD_A_HIGHVOLT_PATH_SELECT]),
    .positive_input_select(cur_a[`SDD_A_POS_LSB +: 4]),
    .negative_input_select(cur_a[`SDD_A_NEG_LSB +: 4]),
    .internal_node_select(cur_a[`SDD_A_NODE_LSB +: 3]),
    .node_route(node_route),
    .select_error(node_select_error)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic mod_strobe;
  logic [24:0] diff;
  logic [23:0] value;
  logic bus_restart;

  always_comb
  begin
    n = r;
    mod_strobe = (r.mod_cnt == `SDD_MOD_DIV - 4'd1);
    diff = '0;
    value = '0;
    bus_restart = 1'b0;
    n.result_valid = 1'b0;
    n.restart = 1'b0;

    // Modulator clock and input sampling.
    n.mod_cnt = mod_strobe ? 4'd0 : r.mod_cnt + 4'd1;
    n.mod_clk = (n.mod_cnt < (`SDD_MOD_DIV >> 1));
    n.sync1 = mod_bit_in;
    n.sync2 = r.sync1;
    n.s1_valid = mod_strobe && (r.state == ST_RUN) && !r.restart;
    n.s1_data = r.sync2 ? `SDD_MOD_POS : `SDD_MOD_NEG;

    // Conversion sequencing.
    case (r.state)
      ST_OFF:
      begin
        if (run_en)
        begin
          n.state = ST_RUN;
          n.restart = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (!run_en)
        begin
          n.state = ST_OFF;
        end
        else if (fo_valid && !r.restart)
        begin
          if (r.skip != 4'd0)
          begin
            n.skip = r.skip - 4'd1;
          end
          else if (chop_en && !r.chop_phase)
          begin
            n.first = fo_data;
            n.chop_phase = 1'b1;
            n.swap = 1'b1;
            n.restart = 1'b1;
          end
          else
          begin
            if (chop_en)
            begin
              diff = {r.first[23], r.first} - {fo_data[23], fo_data};
              value = diff[24:1];
              n.chop_phase = 1'b0;
              n.swap = 1'b0;
              n.restart = 1'b1;
            end
            else
            begin
              value = fo_data;
            end
            if (r.glob[`SDD_GLB_SHORT])
            begin
              n.result = {{8{value[23]}}, value[23:8]};
            end
            else
            begin
              n.result = value;
            end
            n.result_valid = 1'b1;
            n.result_ch = r.chidx;
            n.result_count = r.result_count + 16'd1;
            if (!normal_mode)
            begin
              n.state = ST_HOLD;
              n.wait_cnt = 16'(cur_c[`SDD_C_WAIT_LSB +: 6] * WAIT_UNIT);
            end
          end
        end
      end
      ST_HOLD:
      begin
        if (!run_en)
        begin
          n.state = ST_OFF;
        end
        else if (mod_strobe)
        begin
          if (r.wait_cnt == 16'd0)
          begin
            n.state = ST_RUN;
            n.restart = 1'b1;
          end
          else
          begin
            n.wait_cnt = r.wait_cnt - 16'd1;
          end
        end
      end
      default:
      begin
        n.state = ST_OFF;
      end
    endcase

    // Register bus: one wait cycle, then the access completes.
    if ((avs_read || avs_write) && r.waitreq)
    begin
      n.waitreq = 1'b0;
      case (avs_address)
        `SDD_ADDR_GLOBAL: n.rdata = {16'h0000, r.glob};
        `SDD_ADDR_CHIDX: n.rdata = {29'h0000000, r.chidx};
        `SDD_ADDR_WORD_A: n.rdata = {16'h0000, cur_a};
        `SDD_ADDR_WORD_B: n.rdata = {16'h0000, cur_b};
        `SDD_ADDR_WORD_C: n.rdata = {16'h0000, cur_c};
        `SDD_ADDR_STATUS:
          n.rdata = {r.result_count, 12'h000, r.chop_phase, r.state};
        `SDD_ADDR_RESULT: n.rdata = {{8{r.result[23]}}, r.result};
        default: n.rdata = 32'h00000000;
      endcase
    end
    else
    begin
      n.waitreq = 1'b1;
    end

    if (avs_write && !r.waitreq)
    begin
      case (avs_address)
        `SDD_ADDR_GLOBAL:
        begin
          n.glob = sdd_merge16(r.glob, avs_writedata, avs_byteenable);
          bus_restart = 1'b1;
        end
        `SDD_ADDR_CHIDX:
        begin
          if (avs_byteenable[0] && int'(avs_writedata[2:0]) < NUM_CH)
          begin
            n.chidx = avs_writedata[2:0];
            bus_restart = 1'b1;
          end
        end
        `SDD_ADDR_WORD_A:
        begin
          n.word_a[r.chidx] = sdd_merge16(cur_a, avs_writedata,
                                          avs_byteenable);
          bus_restart = 1'b1;
        end
        `SDD_ADDR_WORD_B:
        begin
          n.word_b[r.chidx] = sdd_merge16(cur_b, avs_writedata,
                                          avs_byteenable);
          bus_restart = 1'b1;
        end
        `SDD_ADDR_WORD_C:
        begin
          n.word_c[r.chidx] = sdd_merge16(cur_c, avs_writedata,
                                          avs_byteenable);
          bus_restart = 1'b1;
        end
        default:
        begin
          bus_restart = 1'b0;
        end
      endcase
    end

    // A setup change abandons the conversion in flight.
    if (bus_restart)
    begin
      n.restart = 1'b1;
      n.chop_phase = 1'b0;
      n.swap = 1'b0;
      if (n.glob[`SDD_GLB_RUN])
      begin
        n.state = ST_RUN;
      end
      else
      begin
        n.state = ST_OFF;
      end
    end

    // Normal mode shows every output; single-cycle mode and both
    // chopped phases hide the unsettled ones.
    if (n.restart)
    begin
      n.skip = (normal_mode && !chop_en) ? 4'd0 : settle_skip;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      r <= '0;
      r.waitreq <= 1'b1;
      r.glob <= `SDD_RST_GLOBAL;
      r.word_a <= {8{`SDD_RST_WORD_A}};
      r.word_b <= {8{`SDD_RST_WORD_B}};
      r.word_c <= {8{`SDD_RST_WORD_C}};
      r.state <= ST_OFF;
    end
    else
    begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq;
  assign mod_clk_out = r.mod_clk;
  assign offset_swap_out = r.swap;
  assign result_data = r.result;
  assign result_valid = r.result_valid;
  assign result_channel = r.result_ch;

endmodule : sdd_decim

// File: dv/sdd_decim_checker.sv
`timescale 1ns/1ps

module sdd_decim_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic mod_clk_out,
  input wire logic offset_swap_out,
  input wire logic [6:0] node_route,
  input wire logic [23:0] result_data,
  input wire logic result_valid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_mod_toggle: assert property (
    !$past(reset) && !$past(reset, 2) |-> mod_clk_out != $past(mod_clk_out))
    else $error("modulator clock did not toggle");
  chk_valid_single: assert property (
    result_valid |=> !result_valid)
    else $error("result strobe longer than one cycle");
  chk_result_gap: assert property (
    result_valid |=> !result_valid [*8])
    else $error("results closer than the smallest ratio allows");
  chk_data_hold: assert property (
    !result_valid |-> $stable(result_data))
    else $error("result data changed without strobe");
  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_bus_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  chk_route_onehot: assert property (
    $onehot0(node_route))
    else $error("more than one node routed");
  chk_swap_quiet: assert property (
    $rose(offset_swap_out) |-> !result_valid)
    else $error("result shown at start of second phase");

  cov_result: cover property (result_valid);
  cov_swap: cover property ($rose(offset_swap_out));
  cov_node: cover property (node_route[0]);
endmodule : sdd_decim_checker

// File: dv/sdd_mod_src.sv
`timescale 1ns/1ps

module sdd_mod_src (
  input wire logic mod_clk,
  input wire logic level,
  output logic mod_bit
);
  // ----------------------------------------------------------------
  // Bit stream
  // ----------------------------------------------------------------
  // A bit is launched on each rising modulator clock so it stands for a
  // whole period before the converter samples it.
  initial mod_bit = 1'b0;
  always @(posedge mod_clk)
  begin
    mod_bit <= level;
  end
endmodule : sdd_mod_src

// File: dv/sdd_decim_tb_top.sv
`timescale 1ns/1ps
`include "sdd_params.svh"

module sdd_decim_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, mod_clk_out, mod_bit_in, offset_swap_out;
  logic node_select_error, result_valid;
  logic level = 1'b1;
  logic [6:0] node_route;
  logic [23:0] result_data;
  logic [2:0] result_channel;
  int n_mismatch = 0;
  int check_count = 0;
  int gap;

  always #2 core_clk = ~core_clk;

  sdd_decim #(.NUM_CH(8), .WAIT_UNIT(1)) dut (.core_clk(core_clk),
    .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mod_clk_out(mod_clk_out),
    .mod_bit_in(mod_bit_in), .offset_swap_out(offset_swap_out),
    .node_route(node_route), .node_select_error(node_select_error),
    .result_data(result_data), .result_valid(result_valid),
    .result_channel(result_channel));
  sdd_mod_src u_src (.mod_clk(mod_clk_out), .level(level),
    .mod_bit(mod_bit_in));

  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task bad(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask : bad

  function automatic logic cmp(input logic d);
    check_count++;
    return d;
  endfunction : cmp

  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      if (!avs_waitrequest)
        break;
    end
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 40)
    begin
      bad("bus hang");
      print_verdict();
    end
  endtask : bus

  // Waits for two results and returns the cycles between them.
  task gp(output int n);
    for (int r = 0; r < 2; r++)
    begin
      n = 0;
      do
      begin
        @(negedge core_clk);
        n++;
      end
      while (!result_valid && n < 9000);
      if (n >= 9000)
      begin
        bad("no result");
        print_verdict();
      end
    end
  endtask : gp

  task t_regs;
    logic [7:0] ad [5] = '{`SDD_ADDR_GLOBAL, `SDD_ADDR_WORD_A,
      `SDD_ADDR_WORD_B, `SDD_ADDR_WORD_C, 8'h1C};
    logic [15:0] ex [5] = '{16'h0000, 16'h0100, 16'h0000, 16'h0001,
      16'h0000};
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b0, ad[k], 16'h0000);
      if (cmp(rdat !== {16'h0000, ex[k]})) bad("reset value");
    end
  endtask : t_regs

  task t_rates;
    int osr [11] = '{8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256};
    for (int c = 0; c < 11; c++)
    begin
      bus(1'b1, `SDD_ADDR_WORD_B, 16'(c) | 16'h0300);
      gp(gap);
      if (cmp(gap != 2 * osr[c])) bad("rate gap");
    end
  endtask : t_rates

  task t_slow;
    for (int o = 1; o < 5; o++)
    begin
      bus(1'b1, `SDD_ADDR_WORD_B, {5'h00, 3'(o), 8'h0C});
      gp(gap);
      if (cmp(gap != 1024)) bad("second stage gap");
      if (cmp(result_data[23] !== 1'b0)) bad("result sign");
    end
  endtask : t_slow

  task t_short;
    level <= 1'b0;
    bus(1'b1, `SDD_ADDR_WORD_B, 16'h0002);
    bus(1'b1, `SDD_ADDR_GLOBAL, 16'h0003);
    gp(gap);
    if (cmp(result_data[23:15] !== 9'h1FF)) bad("short form");
    bus(1'b1, `SDD_ADDR_GLOBAL, 16'h0002);
    gp(gap);
    if (cmp(result_data[23] !== 1'b1)) bad("long form");
    level <= 1'b1;
  endtask : t_short

  task t_single;
    int g0;
    bus(1'b1, `SDD_ADDR_WORD_B, 16'h0000);
    bus(1'b1, `SDD_ADDR_WORD_C, 16'h0000);
    gp(g0);
    if (cmp(g0 < 64)) bad("single cycle rate");
    bus(1'b1, `SDD_ADDR_WORD_C, 16'h0300);
    gp(gap);
    if (cmp(gap != g0 + 2 * 3)) bad("wait setting");
    bus(1'b1, `SDD_ADDR_WORD_C, 16'h0001);
  endtask : t_single

  task t_chop;
    bus(1'b1, `SDD_ADDR_WORD_B, 16'h0002);
    bus(1'b1, `SDD_ADDR_WORD_C, 16'h0003);
    gp(gap);
    if (cmp(gap < 64)) bad("chop rate");
    if (cmp(result_data !== 24'h000000)) bad("chop value");
    bus(1'b1, `SDD_ADDR_WORD_C, 16'h0001);
  endtask : t_chop

  task t_node;
    for (int k = 0; k < 6; k++)
    begin
      bus(1'b1, `SDD_ADDR_WORD_A,
        {1'b0, 3'(k), 4'h0, 4'(9 + k), 4'(9 + k)});
      repeat (3) @(negedge core_clk);
      if (cmp(node_route !== 7'(1 << k) || node_select_error !== 1'b0))
        bad("node route");
    end
    bus(1'b1, `SDD_ADDR_WORD_A, 16'h009A);
    repeat (3) @(negedge core_clk);
    if (cmp(node_select_error !== 1'b1)) bad("node error");
    bus(1'b1, `SDD_ADDR_WORD_A, `SDD_RST_WORD_A);
  endtask : t_node

  // Channel one still holds its reset setup: code 0, normal settling.
  task t_chan;
    bus(1'b1, `SDD_ADDR_CHIDX, 16'h0001);
    bus(1'b0, `SDD_ADDR_CHIDX, 16'h0000);
    if (cmp(rdat !== 32'h00000001)) bad("channel index");
    gp(gap);
    if (cmp(result_channel !== 3'd1)) bad("result channel");
    if (cmp(gap != 2 * 8)) bad("channel rate");
    bus(1'b1, `SDD_ADDR_CHIDX, 16'h0000);
    gp(gap);
    if (cmp(result_channel !== 3'd0)) bad("channel back");
    if (cmp(gap != 2 * 16)) bad("channel back rate");
  endtask : t_chan

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    bus(1'b1, `SDD_ADDR_GLOBAL, 16'h0002);
    t_rates();
    t_slow();
    t_short();
    t_single();
    t_chop();
    t_node();
    t_chan();
    print_verdict();
  end
endmodule : sdd_decim_tb_top

bind sdd_decim sdd_decim_checker u_chk (.core_clk(core_clk),
  .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .mod_clk_out(mod_clk_out),
  .offset_swap_out(offset_swap_out), .node_route(node_route),
  .result_data(result_data), .result_valid(result_valid));
